// ---- bench/wdt_top_tb.sv ----
// self-checking bench for the watchdog core, register model kept in integers
// assumes a one-cycle avalon answer and a slow tick three clocks after each rising osc edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
////////////////////////////////////////////////////////////////////////////////
module wdt_top_tb;
  logic        clk;
  logic        sys_rst;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic        slow_osc;
  logic [1:0]  osc_div;      // slow oscillator runs at a quarter of clk
  logic [3:0]  clr_src;      // clear, osc fail, sleep entry, wake
  logic        startup_busy;
  logic        ready;
  logic        t0_tick;
  logic        t0_out;
  logic        wdt_to;
  logic        wdt_run;
  logic        stable;
  logic [31:0] r;
  int          n_mismatch;
  int          samples_checked;
  int          cycles;
  int          seed;
  int          mctrl;
  int          mopt;
  int          mcfg;
  int          c;

  wdt_top u_dut (
    .CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .SLOW_OSC(slow_osc), .CLR_WDT(clr_src[0]),
    .OSC_FAIL(clr_src[1]), .SLEEP_ENTER(clr_src[2]), .SLEEP_EXIT(clr_src[3]),
    .OST_BUSY(startup_busy), .SLOW_OSC_READY(ready), .T0_TICK(t0_tick),
    .T0_PRESCALED(t0_out), .WDT_TIMEOUT(wdt_to), .WDT_RUNNING(wdt_run),
    .SLOW_OSC_STABLE(stable)
  );
////////////////////////////////////////////////////////////////////////////////
  // clock, slow oscillator and hang guard
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    osc_div  <= osc_div + 2'h1;
    slow_osc <= osc_div[1];
    cycles   <= cycles + 1;
    if (cycles == 60000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    begin
      n = 0;
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= {24'h000000, d};
      be <= b;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (waitreq !== 1'b0 && n < 50);
      q = rdata;
      if (n == 50)
        n_mismatch++;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask

  // write with the model kept in step; bits 7:5 of control never stick
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    begin
      bus(1'b1, a, d, 4'hF, r);
      if (a == 4'h0) mctrl = d & 8'h1F;
      if (a == 4'h4) mopt = d;
      if (a == 4'h8) mcfg = d;
    end
  endtask

  task automatic chk_rd(input logic [3:0] a);
    logic [31:0] e;
    begin
      e = (a == 4'h0) ? 32'(mctrl) : (a == 4'h4) ? 32'(mopt) :
          (a == 4'h8) ? 32'(mcfg) : 32'h00000000;
      bus(1'b0, a, 8'h00, 4'hF, r);
      `CHK("regread", e, r)
    end
  endtask

  // cycles until the next time-out pulse, or lim if none
  task automatic wait_to(input int lim, output int n);
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (wdt_to !== 1'b1 && n < lim);
    end
  endtask

  // second interval is exact; the first may be partial after reprogramming
  task automatic period_case(input int code, input int asg, input int ratio, input int sw);
    int e;
    begin
      e = (1 << (5 + code)) * (asg ? (1 << ratio) : 1) * 4;
      wreg(4'h4, 8'(8'hF0 | (asg << 3) | ratio));
      wreg(4'h0, 8'((code << 1) | sw));
      wait_to(3 * e, c);
      wait_to(3 * e, c);
      `CHK("period", e, c)
    end
  endtask

  // timer0 pulses seen after n input ticks
  task automatic t0_count(input int n, output int cnt);
    begin
      cnt = 0;
      repeat (n + 2)
      begin
        t0_tick <= (n > 0);
        n--;
        @(posedge clk);
        t0_tick <= 1'b0;
        cnt += (t0_out === 1'b1);
        repeat (3)
        begin
          @(posedge clk);
          cnt += (t0_out === 1'b1);
        end
      end
    end
  endtask

  // a clear mid-interval restarts the full 128-cycle count
  task automatic clear_case(input int k);
    begin
      wait_to(400, c);
      repeat (64) @(posedge clk);
      clr_src[k] <= 1'b1;
      @(posedge clk);
      clr_src[k] <= 1'b0;
      @(posedge clk);
      `CHK("run_kept", 1'b1, wdt_run)
      wait_to(400, c);
      `CHK("clr_gap", 1'b1, (c >= 118 && c <= 136))
    end
  endtask
////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rd, wr, addr, wdata, be, clr_src, startup_busy, t0_tick} = '0;
    {osc_div, slow_osc, cycles, n_mismatch, samples_checked} = '0;
    ready = 1'b1;
    sys_rst = 1'b1;
    seed = 57;
    mctrl = 8'h08;
    mopt = 8'hFF;
    mcfg = 8'h00;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK("idle_wait", 1'b1, waitreq)
    `CHK("run_rst", 1'b0, wdt_run)
    chk_rd(4'h0);
    chk_rd(4'h4);
    chk_rd(4'h8);
    chk_rd(4'h2);
    // random traffic, status left alone because its bits move on their own
    repeat (10)
    begin
      c = $random(seed) & 32'h0000000F;
      if (c == 12) c = 0;
      wreg(4'(c), 8'($random(seed)));
      chk_rd(4'(c));
    end
    bus(1'b1, 4'h0, 8'hFF, 4'h0, r);
    chk_rd(4'h0);
    wreg(4'h8, 8'h04);
    wreg(4'h0, 8'h00);
    // timer0 share: divide by 2 and 4, then passthrough
    wreg(4'h4, 8'hF8);
    wreg(4'h4, 8'hF0);
    t0_count(16, c);
    `CHK("t0_div2", 8, c)
    wreg(4'h4, 8'hF9);
    wreg(4'h4, 8'hF1);
    t0_count(16, c);
    `CHK("t0_div4", 4, c)
    wreg(4'h4, 8'hF8);
    t0_count(5, c);
    `CHK("t0_pass", 5, c)
    period_case(0, 0, 7, 1);
    period_case(1, 0, 0, 1);
    period_case(3, 0, 0, 1);
    period_case(0, 1, 0, 1);
    period_case(0, 1, 3, 1);
    period_case(1, 1, 2, 1);
    // hardware enable wins over a cleared software bit
    wreg(4'h8, 8'h0C);
    period_case(0, 0, 0, 0);
    `CHK("hw_run", 1'b1, wdt_run)
    wreg(4'h8, 8'h04);
    @(posedge clk);
    `CHK("sw_off", 1'b0, wdt_run)
    wait_to(300, c);
    `CHK("sw_quiet", 300, c)
    wreg(4'h0, 8'h01);
    @(posedge clk);
    `CHK("sw_on", 1'b1, wdt_run)
    for (int k = 0; k < 4; k++)
      clear_case(k);
    // wake on a crystal clock stays cleared until the start-up timer ends
    wreg(4'h8, 8'h00);
    wait_to(400, c);
    clr_src[3] <= 1'b1;
    @(posedge clk);
    clr_src[3] <= 1'b0;
    startup_busy <= 1'b1;
    wait_to(300, c);
    `CHK("held_quiet", 300, c)
    `CHK("held_run", 1'b0, wdt_run)
    startup_busy <= 1'b0;
    wait_to(400, c);
    `CHK("held_gap", 1'b1, (c >= 118 && c <= 136))
    // stable flag follows system use only, not the watchdog's
    ready <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("stable_lo", 1'b0, stable)
    ready <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("stable_hi", 1'b1, stable)
    // time-out seen flag, write one to clear
    wreg(4'h0, 8'h00);
    bus(1'b0, 4'hC, 8'h00, 4'hF, r);
    `CHK("stat_to", 32'h00000002, r)
    wreg(4'hC, 8'h02);
    bus(1'b0, 4'hC, 8'h00, 4'hF, r);
    `CHK("stat_clr", 32'h00000000, r)
    wrap_up();
  end
endmodule // wdt_top_tb
`default_nettype wire

// ---- hdl/wdt_cfg.svh ----
// watchdog constants: register offsets, field positions, reset values
// assumes inclusion by bare name from the design files of the watchdog
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// register byte offsets on the avalon slave
`define WDT_OFS_CTRL     4'h0
`define WDT_OFS_OPT      4'h4
`define WDT_OFS_CFG      4'h8
`define WDT_OFS_STAT     4'hC

// reset values
`define WDT_CTRL_RST     8'h08
`define WDT_OPT_RST      8'hFF
`define WDT_CFG_RST      8'h00

// watchdog_control fields
`define WDT_CTRL_MASK    8'h1F
`define WDT_SWEN_BIT     0
`define WDT_PSEL_MSB     4
`define WDT_PSEL_LSB     1
`define WDT_PSEL_MAX     4'hB

// option_settings fields
`define WDT_PSA_BIT      3
`define WDT_RATIO_MSB    2

// configuration_word fields
`define WDT_HWEN_BIT     3
`define WDT_FOSC_MSB     2

// status fields
`define WDT_STAT_RUN_BIT 0
`define WDT_STAT_TO_BIT  1
`define WDT_STAT_OST_BIT 2

// chain masks
`define WDT_PRE_FULL     16'hFFFF
`define WDT_POST_FULL    8'hFF
`define WDT_RATIO_MAX    3'h7

`endif

// ---- hdl/wdt_pkg.sv ----
// watchdog types shared by the top and the shared prescaler
// assumes nothing beyond a systemverilog compiler
package wdt_pkg;

  typedef logic [7:0] reg8_type;
  typedef logic [3:0] period_type;
  typedef logic [2:0] ratio_type;

  // system clock source codes held in configuration_word
  typedef enum logic [2:0] {
    FOSC_CRYSTAL_LOW_POWER  = 3'h0,
    FOSC_CRYSTAL_MEDIUM     = 3'h1,
    FOSC_CRYSTAL_HIGH_SPEED = 3'h2,
    FOSC_EXTERNAL_RC        = 3'h3,
    FOSC_INTERNAL_OSC       = 3'h4,
    FOSC_EXTERNAL_CLOCK     = 3'h5,
    FOSC_TIMER1_OSC         = 3'h6,
    FOSC_SPARE              = 3'h7
  } fosc_type;

endpackage

// ---- hdl/wdt_ps_if.sv ----
// carrier between the watchdog top and the shared 8-bit prescaler
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none

interface wdt_ps_if;
  logic               clr;
  logic               wdt_tick;
  logic               t0_tick;
  logic               assign_wdt;
  wdt_pkg::ratio_type ratio;
  logic               wdt_out;
  logic               t0_out;

  modport scaler (input clr, wdt_tick, t0_tick, assign_wdt, ratio, output wdt_out, t0_out);
  modport user   (output clr, wdt_tick, t0_tick, assign_wdt, ratio, input wdt_out, t0_out);
endinterface

`default_nettype wire

// ---- hdl/wdt_shared_prescaler.sv ----
// shared 8-bit scaler, serving either the watchdog or timer0
// assumes ticks are one-cycle pulses on CLK from the same domain
`timescale 1ns/10ps
`default_nettype none
`include "wdt_cfg.svh"

module wdt_shared_prescaler (
  input  wire logic   clk,    // system clock
  input  wire logic   rst,    // synchronous reset, high
  wdt_ps_if.scaler    ps      // scaler side of the carrier
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       prev_assign;
  logic [7:0] full_mask;
  logic [7:0] mask;
  logic       tick_in;
  logic       term;
  logic       clr_now;

  ////////////////////////////////////////////////////////////////////////
  // terminal count: 2^ratio for the watchdog, 2^(ratio+1) for timer0
  always_comb
  begin
    full_mask = `WDT_POST_FULL >> (`WDT_RATIO_MAX - ps.ratio);
    mask      = ps.assign_wdt ? (full_mask >> 1) : full_mask;
    tick_in   = ps.assign_wdt ? ps.wdt_tick : ps.t0_tick;
    term      = tick_in && ((cnt & mask) == mask);
    // a change of owner restarts the count so no stale partial count leaks
    clr_now   = (ps.clr && ps.assign_wdt) || (prev_assign != ps.assign_wdt);
    if (clr_now)
      next_cnt = 8'h00;
    else if (term)
      next_cnt = 8'h00;
    else if (tick_in)
      next_cnt = cnt + 8'h01;
    else
      next_cnt = cnt;
    ps.wdt_out = ps.assign_wdt ? (term && !clr_now) : ps.wdt_tick;
    ps.t0_out  = ps.assign_wdt ? ps.t0_tick : (term && !clr_now);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt         <= 8'h00;
      prev_assign <= 1'b1;
    end
    else
    begin
      cnt         <= next_cnt;
      prev_assign <= ps.assign_wdt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_T0_PASSTHRU: assert property (ps.assign_wdt |-> ps.t0_out == ps.t0_tick)
    else $error("timer0 tick not passed through while scaler serves watchdog");
  AST_WDT_BYPASS: assert property (!ps.assign_wdt && !ps.t0_tick
    && prev_assign == ps.assign_wdt |=> $stable(cnt))
    else $error("watchdog tick moved the scaler while it serves timer0");

endmodule // wdt_shared_prescaler

`default_nettype wire

// ---- hdl/wdt_top.sv ----
// watchdog timer core with avalon-mm register slave
// assumes a 250 MHz CLK, slow oscillator on a pin, control pulses on CLK
`timescale 1ns/10ps
`default_nettype none
`include "wdt_cfg.svh"

module wdt_top (
  input  wire logic        CLK,             // 250 MHz system clock
  input  wire logic        SYS_RST,         // synchronous reset, high
  input  wire logic [3:0]  AVS_ADDRESS,     // byte address
  input  wire logic        AVS_READ,        // read request
  input  wire logic        AVS_WRITE,       // write request
  input  wire logic [31:0] AVS_WRITEDATA,   // write data
  input  wire logic [3:0]  AVS_BYTEENABLE,  // byte lanes
  output var  logic [31:0] AVS_READDATA,    // read data
  output var  logic        AVS_WAITREQUEST, // stall
  input  wire logic        SLOW_OSC,        // 31 kHz oscillator pin
  input  wire logic        CLR_WDT,         // clear instruction pulse
  input  wire logic        OSC_FAIL,        // oscillator failure pulse
  input  wire logic        SLEEP_ENTER,     // sleep entry pulse
  input  wire logic        SLEEP_EXIT,      // wake-up pulse
  input  wire logic        OST_BUSY,        // start-up timer running
  input  wire logic        SLOW_OSC_READY,  // slow osc up for system use
  input  wire logic        T0_TICK,         // timer0 clock pulse
  output var  logic        T0_PRESCALED,    // timer0 scaled pulse
  output var  logic        WDT_TIMEOUT,     // time-out pulse
  output var  logic        WDT_RUNNING,     // watchdog counting
  output var  logic        SLOW_OSC_STABLE  // stable flag for software
);

  wdt_ps_if psif ();

  wdt_pkg::reg8_type  ctrl;
  wdt_pkg::reg8_type  opt;
  wdt_pkg::reg8_type  cfg;
  wdt_pkg::reg8_type  next_ctrl;
  wdt_pkg::reg8_type  next_opt;
  wdt_pkg::reg8_type  next_cfg;
  logic [15:0]        pre;
  logic [15:0]        next_pre;
  logic               osc_s0;
  logic               osc_s1;
  logic               osc_s2;
  logic               ost_hold;
  logic               next_ost_hold;
  logic               ost_prev;
  logic               seen_to;
  logic               next_seen_to;
  logic               next_waitreq;
  logic [31:0]        next_rdata;
  logic               next_timeout;
  logic               next_running;
  logic               next_t0;
  logic               next_stable;

  logic               slow_tick;
  logic               enabled;
  logic               crystal;
  logic               clear_all;
  wdt_pkg::period_type period;
  logic [15:0]        pre_mask;
  logic               pre_term;
  logic               wr_done;
  wdt_pkg::fosc_type  fosc;

  ////////////////////////////////////////////////////////////////////////
  // enable, clear and chain terms
  always_comb
  begin
    // edge of the synchronised oscillator; the first flop is never read here
    slow_tick = osc_s1 && !osc_s2;
    // hardware enable overrides the software bit; either one starts the chain
    enabled   = cfg[`WDT_HWEN_BIT] || ctrl[`WDT_SWEN_BIT];
    fosc      = wdt_pkg::fosc_type'(cfg[`WDT_FOSC_MSB:0]);
    crystal   = (fosc == wdt_pkg::FOSC_CRYSTAL_LOW_POWER)
             || (fosc == wdt_pkg::FOSC_CRYSTAL_MEDIUM)
             || (fosc == wdt_pkg::FOSC_CRYSTAL_HIGH_SPEED);
    // every clear source, including the start-up timer borrowing the counter
    clear_all = !enabled || CLR_WDT || OSC_FAIL || SLEEP_EXIT
             || SLEEP_ENTER || OST_BUSY || ost_hold;
    // reserved codes clamp to the longest ratio rather than misbehave
    period    = (ctrl[`WDT_PSEL_MSB:`WDT_PSEL_LSB] > `WDT_PSEL_MAX)
              ? `WDT_PSEL_MAX : ctrl[`WDT_PSEL_MSB:`WDT_PSEL_LSB];
    pre_mask  = `WDT_PRE_FULL >> (`WDT_PSEL_MAX - period);
    // low bits all ones wraps even after the period is shortened mid-count
    pre_term  = slow_tick && ((pre & pre_mask) == pre_mask);
  end

  // shared scaler hookup
  // watchdog ticks are gated by the clears so a cleared chain cannot time out
  assign psif.clr        = clear_all;
  assign psif.wdt_tick   = pre_term && !clear_all;
  assign psif.t0_tick    = T0_TICK;
  assign psif.assign_wdt = opt[`WDT_PSA_BIT];
  assign psif.ratio      = opt[`WDT_RATIO_MSB:0];

  wdt_shared_prescaler u_scaler (
    .clk (CLK),
    .rst (SYS_RST),
    .ps  (psif.scaler)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state of counter, holds, registers and bus
  always_comb
  begin
    // a write lands only in the answer cycle and only with lane 0 set
    wr_done = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    // prescaler count
    if (clear_all)
      next_pre = 16'h0000;
    else if (pre_term)
      next_pre = 16'h0000;
    else if (slow_tick)
      next_pre = pre + 16'h0001;
    else
      next_pre = pre;
    // crystal wake-up waits for the start-up timer to finish
    if (SLEEP_EXIT && crystal)
      next_ost_hold = 1'b1;
    else if (ost_prev && !OST_BUSY)
      next_ost_hold = 1'b0;
    else
      next_ost_hold = ost_hold;
    // register writes
    next_ctrl = ctrl;
    next_opt  = opt;
    next_cfg  = cfg;
    if (wr_done && AVS_ADDRESS == `WDT_OFS_CTRL)
      next_ctrl = AVS_WRITEDATA[7:0] & `WDT_CTRL_MASK;
    if (wr_done && AVS_ADDRESS == `WDT_OFS_OPT)
      next_opt = AVS_WRITEDATA[7:0];
    if (wr_done && AVS_ADDRESS == `WDT_OFS_CFG)
      next_cfg = AVS_WRITEDATA[7:0];
    // sticky time-out seen, write one to clear; a new time-out wins
    next_seen_to = seen_to;
    if (wr_done && AVS_ADDRESS == `WDT_OFS_STAT && AVS_WRITEDATA[`WDT_STAT_TO_BIT])
      next_seen_to = 1'b0;
    if (psif.wdt_out)
      next_seen_to = 1'b1;
    // bus answer one cycle after the request is seen
    next_waitreq = !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
    // read data fall back to zero after the answer cycle, where they are taken
    next_rdata   = 32'h0000_0000;
    if (AVS_READ && AVS_WAITREQUEST)
    begin
      case (AVS_ADDRESS)
        `WDT_OFS_CTRL: next_rdata[7:0] = ctrl & `WDT_CTRL_MASK;
        `WDT_OFS_OPT:  next_rdata[7:0] = opt;
        `WDT_OFS_CFG:  next_rdata[7:0] = cfg;
        `WDT_OFS_STAT:
        begin
          next_rdata[`WDT_STAT_RUN_BIT] = WDT_RUNNING;
          next_rdata[`WDT_STAT_TO_BIT]  = seen_to;
          next_rdata[`WDT_STAT_OST_BIT] = ost_hold;
        end
        default:       next_rdata = 32'h0000_0000;
      endcase
    end
    // outputs
    next_timeout = psif.wdt_out;
    next_running = enabled && !OST_BUSY && !ost_hold;
    next_t0      = psif.t0_out;
    // watchdog enable deliberately kept out of the stable flag
    next_stable  = SLOW_OSC_READY;
  end

  // state registers
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ctrl            <= `WDT_CTRL_RST;
      opt             <= `WDT_OPT_RST;
      cfg             <= `WDT_CFG_RST;
      pre             <= 16'h0000;
      osc_s0          <= 1'b0;
      osc_s1          <= 1'b0;
      osc_s2          <= 1'b0;
      ost_hold        <= 1'b0;
      ost_prev        <= 1'b0;
      seen_to         <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
      WDT_TIMEOUT     <= 1'b0;
      WDT_RUNNING     <= 1'b0;
      T0_PRESCALED    <= 1'b0;
      SLOW_OSC_STABLE <= 1'b0;
    end
    else
    begin
      ctrl            <= next_ctrl;
      opt             <= next_opt;
      cfg             <= next_cfg;
      pre             <= next_pre;
      osc_s0          <= SLOW_OSC;
      osc_s1          <= osc_s0;
      osc_s2          <= osc_s1;
      ost_hold        <= next_ost_hold;
      ost_prev        <= OST_BUSY;
      seen_to         <= next_seen_to;
      AVS_WAITREQUEST <= next_waitreq;
      AVS_READDATA    <= next_rdata;
      WDT_TIMEOUT     <= next_timeout;
      WDT_RUNNING     <= next_running;
      T0_PRESCALED    <= next_t0;
      SLOW_OSC_STABLE <= next_stable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence seq_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence

  sequence seq_answer;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  sequence seq_crystal_wake;
    SLEEP_EXIT && crystal;
  endsequence

  sequence seq_ost_release;
    ost_hold && ost_prev && !OST_BUSY && !(SLEEP_EXIT && crystal);
  endsequence

  sequence seq_idle_tick;
    !slow_tick && !clear_all;
  endsequence

  AST_BUS_ANSWER: assert property (seq_req |=> seq_answer)
    else $error("bus answer not given one cycle after request");
  AST_CTRL_RESET: assert property ($fell(SYS_RST) |-> ctrl == `WDT_CTRL_RST)
    else $error("control register not at reset value after reset");
  AST_UNIMPL_BITS: assert property (wr_done |=> ctrl[7:5] == 3'h0)
    else $error("unimplemented control bits took a write");
  AST_HW_FORCE: assert property (cfg[`WDT_HWEN_BIT] && !OST_BUSY && !ost_hold |=> WDT_RUNNING)
    else $error("hardware enable did not force watchdog on");
  AST_SW_STOP: assert property (!cfg[`WDT_HWEN_BIT] && !ctrl[`WDT_SWEN_BIT] |=> pre == 16'h0000 && !WDT_RUNNING)
    else $error("software disable did not stop and clear watchdog");
  AST_CLEAR_SRC: assert property (CLR_WDT || OSC_FAIL |=> pre == 16'h0000)
    else $error("clear source did not clear count");
  AST_OST_HOLD: assert property (OST_BUSY |=> pre == 16'h0000 && !WDT_RUNNING)
    else $error("count moved while start-up timer busy");
  AST_CRYSTAL_WAKE: assert property (seq_crystal_wake |=> ost_hold && pre == 16'h0000)
    else $error("crystal wake did not hold watchdog cleared");
  AST_SLEEP_KEEP: assert property (SLEEP_ENTER && enabled && !OST_BUSY && !ost_hold |=> pre == 16'h0000 && WDT_RUNNING)
    else $error("sleep entry did not clear and keep running");
  AST_WAKE_CLEAR: assert property (SLEEP_EXIT |=> pre == 16'h0000)
    else $error("wake from sleep did not clear count");
  AST_PRE_WRAP: assert property (pre_term && !clear_all |=> pre == 16'h0000)
    else $error("prescaler did not wrap at selected ratio");
  AST_STABLE_FLAG: assert property (!SLOW_OSC_READY |=> !SLOW_OSC_STABLE)
    else $error("stable flag set by watchdog use");
  AST_TIMEOUT_CAUSE: assert property (WDT_TIMEOUT |-> $past(enabled) && !$past(clear_all))
    else $error("time-out without running chain");

  // further guards on the chain, the start-up hold and the read path
  AST_TICK_ONLY: assert property (seq_idle_tick |=> $stable(pre))
    else $error("prescaler moved without a slow oscillator tick");
  AST_OST_RELEASE: assert property (seq_ost_release |=> !ost_hold)
    else $error("start-up hold outlived the start-up timer");
  AST_HOLD_STOPS: assert property (ost_hold |=> !WDT_RUNNING && pre == 16'h0000)
    else $error("watchdog ran during crystal start-up hold");
  AST_TIMEOUT_PULSE: assert property (WDT_TIMEOUT |=> !WDT_TIMEOUT)
    else $error("time-out pulse lasted more than one cycle");
  AST_SEEN_SET: assert property (psif.wdt_out |=> seen_to)
    else $error("time-out not recorded in status");
  AST_SCALER_CLEAR: assert property (clear_all |=> !WDT_TIMEOUT)
    else $error("time-out raised in the cycle after a clear");
  AST_RESERVED_CODE: assert property (ctrl[`WDT_PSEL_MSB:`WDT_PSEL_LSB] > `WDT_PSEL_MAX
    |-> pre_mask == `WDT_PRE_FULL)
    else $error("reserved period code did not act as the longest ratio");
  AST_STABLE_FOLLOW: assert property (SLOW_OSC_READY |=> SLOW_OSC_STABLE)
    else $error("stable flag did not follow system use of the oscillator");
  AST_CTRL_READ: assert property (!AVS_WAITREQUEST && $past(AVS_READ)
    && $past(AVS_ADDRESS) == `WDT_OFS_CTRL |-> AVS_READDATA[7:5] == 3'h0)
    else $error("unimplemented control bits read as nonzero");
  AST_RESET_IDLE: assert property ($fell(SYS_RST) |-> AVS_WAITREQUEST && !WDT_TIMEOUT)
    else $error("outputs not idle after reset");

endmodule // wdt_top

`default_nettype wire
